// >>> rtl/dpt_defs.svh
// constants for the drive protection and trip block
// assumes a 250 MHz core clock and a 0.1 s protection time base
`ifndef DPT_DEFS_SVH
`define DPT_DEFS_SVH
`define DPT_CLK_HZ 250000000
`define DPT_TICK_MS 100
`define DPT_TICK_CYC ((`DPT_CLK_HZ / 1000) * `DPT_TICK_MS)
`define DPT_FAN_MODE_TRIP 1'h0
`define DPT_FAN_MODE_WARN 1'h1
`define DPT_OUT_FN_FAN_WARN 4'h8
`define DPT_OUT_FN_LOW_VOLT 4'hb
`define DPT_IN_FN_BLOCK 4'h5
`define DPT_TIME_ZERO 13'h0000
`define DPT_NUM_OUT 3
`define DPT_NUM_IN 8
`endif

// >>> rtl/dpt_pkg.sv
// types shared by the drive protection and trip block
// assumes dpt_defs.svh is compiled alongside
package dpt_pkg;
  // state of the output-block input handling
  typedef enum logic [3:0]
  {
    DPT_RUN = 4'h1,
    DPT_DECEL = 4'h2,
    DPT_CUT = 4'h4,
    DPT_WAIT_RUN = 4'h8
  } dpt_blk_e;
  // monitor snapshot at the block instant
  typedef struct packed
  {
    logic [15:0] freq;
    logic [15:0] curr;
  } dpt_mon_s;
  // fault and indication flags
  typedef struct packed
  {
    logic fan_trip;
    logic lv_trip;
    logic block_shown;
  } dpt_ind_s;
endpackage : dpt_pkg

// >>> rtl/dpt_tick_gen.sv
// time base tick generator, one pulse every 0.1 s of core clock
// assumes a free running core_clk
`timescale 1ns/100ps
`include "dpt_defs.svh"
module dpt_tick_gen #(
  parameter int unsigned TICK_CYC = `DPT_TICK_CYC
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  output logic tick // one-cycle pulse per time step
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_tick;
  // next count; wraps at the tick period
  always_comb
  begin
    next_cnt = cnt + 32'h1;
    next_tick = 1'b0;
    if (cnt >= TICK_CYC - 1)
    begin
      next_cnt = 32'h0;
      next_tick = 1'b1; // see (R13)
    end
  end
  // register count and tick
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : dpt_tick_gen

// >>> rtl/dpt_protect.sv
// drive protection: fan fault, low dc-link voltage, output-block input
// assumes pin-level status inputs asynchronous; settings and monitor quasi-static
//
// Contract
// (R1) fan mode 0 and fan error: block output, show fan trip
// (R2) fan mode 1: fan error drives outputs set to code 8, run continues
// (R3) in fan warning mode, overheat still blocks the output
// (R4) low voltage blocks output at once, trip after programmed delay
// (R5) low voltage warning ignores the trip delay
// (R6) outputs set to code 11 show the low voltage condition
// (R7) block input with code 5 on during run: block output, show indication
// (R8) frequency and current captured at block instant held for monitoring
// (R9) resume only after block input off and a new run command
// (R10) block stop time zero: cut output immediately, free run
// (R11) nonzero block stop time: decelerate over that time
// (R12) user picks a deceleration time suited to capacity and load
// (R13) delays counted on a 0.1 s time base from core clock
`timescale 1ns/100ps
`include "dpt_defs.svh"
module dpt_protect #(
  parameter int unsigned TICK_CYC = `DPT_TICK_CYC,
  parameter int unsigned NUM_OUT = `DPT_NUM_OUT,
  parameter int unsigned NUM_IN = `DPT_NUM_IN
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic fan_err_pin, // cooling fan error, async
  input wire logic overheat_pin, // internal overtemperature, async
  input wire logic low_volt_pin, // dc-link under voltage, async
  input wire logic run_cmd_pin, // run command, async
  input wire logic [NUM_IN-1:0] mf_in_pin, // multifunction inputs, async
  input wire logic fan_mode, // 0 trip, 1 warning
  input wire logic [12:0] undervoltage_trip_delay, // 0.1 s steps
  input wire logic [12:0] block_stop_time, // 0.1 s steps
  input wire logic [NUM_IN*4-1:0] multifunction_input_function, // per input
  input wire logic [NUM_OUT*4-1:0] relay_out_function, // per output
  input wire logic [15:0] freq_now, // present output frequency
  input wire logic [15:0] curr_now, // present output current
  output logic gate_enable, // power stage enable
  output logic decel_req, // timed deceleration request
  output logic [NUM_OUT-1:0] relay_out, // relay and open collector outputs
  output dpt_pkg::dpt_ind_s ind, // trip and display flags
  output dpt_pkg::dpt_mon_s mon // frozen monitor values
);
  ////////////////////////////////////////////////////////////////////
  // synchronisers
  localparam int unsigned SW = 4 + NUM_IN;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {mf_in_pin, run_cmd_pin, low_volt_pin, overheat_pin, fan_err_pin};
      sync2 <= sync1;
    end
  end
  logic fan_err;
  logic overheat;
  logic low_volt;
  logic run_cmd;
  logic [NUM_IN-1:0] mf_in;
  assign fan_err = sync2[0];
  assign overheat = sync2[1];
  assign low_volt = sync2[2];
  assign run_cmd = sync2[3];
  assign mf_in = sync2[SW-1:4];

  ////////////////////////////////////////////////////////////////////
  // time base
  logic tick;
  dpt_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////
  // block input decode, one bit per input
  logic [NUM_IN-1:0] blk_hit;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_in
      assign blk_hit[gi] = mf_in[gi] &&
        (multifunction_input_function[gi*4 +: 4] == `DPT_IN_FN_BLOCK); // see (R7)
    end
  endgenerate
  logic blk_in;
  assign blk_in = |blk_hit;

  ////////////////////////////////////////////////////////////////////
  // trip state and low voltage delay
  logic fan_trip;
  logic lv_trip;
  logic [12:0] lv_cnt;
  logic next_fan_trip;
  logic next_lv_trip;
  logic [12:0] next_lv_cnt;
  // fan trip latches; low voltage trip declared after delay
  always_comb
  begin
    next_fan_trip = fan_trip;
    next_lv_trip = lv_trip;
    next_lv_cnt = lv_cnt;
    if (fan_err && fan_mode == `DPT_FAN_MODE_TRIP)
      next_fan_trip = 1'b1; // see (R1)
    if (!low_volt)
      next_lv_cnt = `DPT_TIME_ZERO;
    else if (lv_cnt >= undervoltage_trip_delay)
      next_lv_trip = 1'b1; // see (R4)
    else if (tick)
      next_lv_cnt = lv_cnt + 13'h1; // see (R13)
  end
  // trips hold until reset; trip-reset handling lives elsewhere
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fan_trip <= 1'b0;
      lv_trip <= 1'b0;
      lv_cnt <= `DPT_TIME_ZERO;
    end
    else
    begin
      fan_trip <= next_fan_trip;
      lv_trip <= next_lv_trip;
      lv_cnt <= next_lv_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output-block state machine
  dpt_pkg::dpt_blk_e blk_st;
  dpt_pkg::dpt_blk_e next_blk_st;
  logic [12:0] dec_cnt;
  logic [12:0] next_dec_cnt;
  dpt_pkg::dpt_mon_s next_mon;
  always_comb
  begin
    next_blk_st = blk_st;
    next_dec_cnt = dec_cnt;
    next_mon = mon;
    unique case (blk_st)
      dpt_pkg::DPT_RUN:
        if (blk_in && run_cmd)
        begin
          next_mon = '{freq: freq_now, curr: curr_now}; // see (R8)
          next_dec_cnt = `DPT_TIME_ZERO;
          if (block_stop_time == `DPT_TIME_ZERO)
            next_blk_st = dpt_pkg::DPT_CUT; // see (R10)
          else
            next_blk_st = dpt_pkg::DPT_DECEL; // see (R11)
        end
      dpt_pkg::DPT_DECEL:
        if (dec_cnt >= block_stop_time)
          next_blk_st = dpt_pkg::DPT_CUT;
        else if (tick)
          next_dec_cnt = dec_cnt + 13'h1; // see (R11)
      dpt_pkg::DPT_CUT:
        if (!blk_in)
          next_blk_st = dpt_pkg::DPT_WAIT_RUN;
      dpt_pkg::DPT_WAIT_RUN:
        if (blk_in)
          next_blk_st = dpt_pkg::DPT_CUT;
        else if (!run_cmd)
          next_blk_st = dpt_pkg::DPT_RUN; // see (R9) fresh command needs a release first
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blk_st <= dpt_pkg::DPT_RUN;
      dec_cnt <= `DPT_TIME_ZERO;
      mon <= '0;
    end
    else
    begin
      blk_st <= next_blk_st;
      dec_cnt <= next_dec_cnt;
      mon <= next_mon;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all registered
  logic [NUM_OUT-1:0] next_relay;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_out
      always_comb
      begin
        next_relay[gi] = 1'b0;
        if (relay_out_function[gi*4 +: 4] == `DPT_OUT_FN_FAN_WARN)
          next_relay[gi] = fan_err && (fan_mode == `DPT_FAN_MODE_WARN); // see (R2)
        else if (relay_out_function[gi*4 +: 4] == `DPT_OUT_FN_LOW_VOLT)
          next_relay[gi] = low_volt; // see (R5) see (R6)
      end
    end
  endgenerate
  logic next_gate;
  logic next_decel;
  dpt_pkg::dpt_ind_s next_ind;
  // gate cut on fan trip, overheat, low voltage or block cut, not on a held low voltage trip; fan warning alone keeps running
  always_comb
  begin
    next_gate = !(fan_trip || next_fan_trip || overheat || low_volt ||
      blk_st == dpt_pkg::DPT_CUT || blk_st == dpt_pkg::DPT_WAIT_RUN); // see (R3) see (R4)
    next_decel = (blk_st == dpt_pkg::DPT_DECEL);
    next_ind.fan_trip = next_fan_trip;
    next_ind.lv_trip = next_lv_trip;
    next_ind.block_shown = (blk_st != dpt_pkg::DPT_RUN); // see (R7)
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_enable <= 1'b0;
      decel_req <= 1'b0;
      relay_out <= '0;
      ind <= '0;
    end
    else
    begin
      gate_enable <= next_gate;
      decel_req <= next_decel;
      relay_out <= next_relay;
      ind <= next_ind;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  AST_FAN_TRIP: assert property (@(posedge core_clk) disable iff (!rst_n)
    fan_err && !fan_mode |=> !gate_enable && ind.fan_trip) // see (R1)
    else $error("fan trip did not block output");
  AST_FAN_WARN: assert property (@(posedge core_clk) disable iff (!rst_n)
    fan_err && fan_mode && relay_out_function[3:0] == `DPT_OUT_FN_FAN_WARN
    |=> relay_out[0]) // see (R2)
    else $error("fan warning not driven");
  AST_OVERHEAT: assert property (@(posedge core_clk) disable iff (!rst_n)
    overheat |=> !gate_enable) // see (R3)
    else $error("overheat did not block output");
  AST_LV_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_n)
    low_volt |=> !gate_enable) // see (R4)
    else $error("low voltage did not block output");
  AST_LV_NO_EARLY: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(low_volt) && !lv_trip && undervoltage_trip_delay != `DPT_TIME_ZERO
    |=> !ind.lv_trip) // see (R4)
    else $error("low voltage trip declared early");
  AST_LV_WARN: assert property (@(posedge core_clk) disable iff (!rst_n)
    low_volt && relay_out_function[7:4] == `DPT_OUT_FN_LOW_VOLT |=> relay_out[1]) // see (R5)
    else $error("low voltage warning delayed");
  AST_BLK_CUT: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk_st == dpt_pkg::DPT_RUN && blk_in && run_cmd && block_stop_time == `DPT_TIME_ZERO
    |=> ##1 !gate_enable && ind.block_shown) // see (R10)
    else $error("block input did not cut output");
  AST_BLK_DEC: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk_st == dpt_pkg::DPT_RUN && blk_in && run_cmd && block_stop_time != `DPT_TIME_ZERO
    |=> ##1 decel_req) // see (R11)
    else $error("block input did not decelerate");
  AST_MON_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk_st != dpt_pkg::DPT_RUN && $past(blk_st) != dpt_pkg::DPT_RUN |-> $stable(mon)) // see (R8)
    else $error("monitor changed while blocked");
  AST_RESUME: assert property (@(posedge core_clk) disable iff (!rst_n)
    blk_st == dpt_pkg::DPT_WAIT_RUN && run_cmd |=> blk_st != dpt_pkg::DPT_RUN) // see (R9)
    else $error("resumed without fresh run command");
endmodule : dpt_protect

// >>> test/dpt_stage_model.sv
// power stage stand-in: follows the gate and deceleration requests
// assumes the bench sets the steady frequency and current targets
`timescale 1ns/100ps
module dpt_stage_model (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic gate_enable, // stage enable
  input wire logic decel_req, // ramp down request
  input wire logic [15:0] freq_set, // steady frequency
  input wire logic [15:0] curr_set, // steady current
  output logic [15:0] freq_now, // live frequency
  output logic [15:0] curr_now // live current
);
  // off or ramping values keep moving, so a stale capture shows up
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freq_now <= 16'h0000;
      curr_now <= 16'h0000;
    end
    else if (gate_enable && !decel_req)
    begin
      freq_now <= freq_set;
      curr_now <= curr_set;
    end
    else
    begin
      freq_now <= freq_now >> 1;
      curr_now <= ~curr_now;
    end
  end
endmodule : dpt_stage_model

// >>> test/drive_protection_trip_logic_test.sv
// bench for the protection block: random settings among corner cases
// assumes dpt_protect and dpt_stage_model are compiled before it
`timescale 1ns/100ps
module drive_protection_trip_logic_test;
  localparam int TC = 10;
  logic core_clk = 0, rst_n = 0, fan = 0, hot = 0, lv = 0, run = 0, fan_mode = 0;
  logic [7:0] mf = 8'h00;
  logic [12:0] lvd = 13'h0000, bst = 13'h0000;
  logic [31:0] mff = 32'h0, seed = 32'hce9c, tgt = 32'h0, emon;
  logic [11:0] rof = 12'h0;
  logic [15:0] fq, cu;
  logic ge, dr;
  logic [2:0] ro;
  dpt_pkg::dpt_ind_s ind;
  dpt_pkg::dpt_mon_s mon;
  int errors = 0, cmp_count = 0;
  always #2 core_clk = ~core_clk;
  dpt_protect #(.TICK_CYC(TC)) u_dpt_protect (.core_clk(core_clk), .rst_n(rst_n),
    .fan_err_pin(fan), .overheat_pin(hot), .low_volt_pin(lv), .run_cmd_pin(run),
    .mf_in_pin(mf), .fan_mode(fan_mode), .undervoltage_trip_delay(lvd),
    .block_stop_time(bst), .multifunction_input_function(mff),
    .relay_out_function(rof), .freq_now(fq), .curr_now(cu), .gate_enable(ge),
    .decel_req(dr), .relay_out(ro), .ind(ind), .mon(mon));
  dpt_stage_model u_dpt_stage_model (.core_clk(core_clk), .rst_n(rst_n),
    .gate_enable(ge), .decel_req(dr), .freq_set(tgt[15:0]), .curr_set(tgt[31:16]),
    .freq_now(fq), .curr_now(cu));
  //////////////////////////////////////////////////////////////////////////////
  // wait n edges, then let that edge's updates land
  task wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task results;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  // trips latch until reset, so each case starts from a fresh reset
  task restart;
    rst_n <= 1'b0;
    {fan, hot, lv, run, mf} <= 12'h000;
    wt(6);
    rst_n <= 1'b1;
    run <= 1'b1;
    wt(8);
  endtask : restart
  // expected relay level from its code and the live conditions
  function logic [2:0] rly(input logic f, input logic l);
    for (int i = 0; i < 3; i++)
      rly[i] = (rof[4*i+:4] == 4'h8 && f) || (rof[4*i+:4] == 4'hb && l);
  endfunction : rly
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mff = $random(seed) | 32'h88888888;
    mff[11:8] = 4'h5;
    tgt = $random(seed);
    rof = {2'b00, tgt[1:0], 4'hb, 4'h8};
    // fan warning mode keeps running until overheat
    fan_mode <= 1'b1;
    restart;
    fan <= 1'b1;
    wt(5);
    chk(ge, 1'b1);
    chk(ro, rly(1'b1, 1'b0));
    chk(ind.fan_trip, 1'b0);
    hot <= 1'b1;
    wt(5);
    chk(ge, 1'b0);
    // fan trip mode
    fan_mode <= 1'b0;
    restart;
    fan <= 1'b1;
    wt(5);
    chk(ge, 1'b0);
    chk(ind.fan_trip, 1'b1);
    chk(ro, rly(1'b0, 1'b0));
    // low voltage with zero and random delay
    for (int k = 0; k < 2; k++)
    begin
      lvd <= k ? 13'h2 + 13'($random(seed) & 3) : 13'h0;
      restart;
      lv <= 1'b1;
      wt(5);
      chk(ge, 1'b0);
      chk(ro, rly(1'b0, 1'b1));
      chk(ind.lv_trip, !k);
      wt(lvd * TC + TC);
      chk(ind.lv_trip, 1'b1);
    end
    // block input, free run, capture and resume
    restart;
    emon = {tgt[15:0], tgt[31:16]};
    mf <= 8'h04 | 8'($random(seed));
    wt(5);
    chk(ge, 1'b0);
    chk(dr, 1'b0);
    chk(ind.block_shown, 1'b1);
    tgt <= $random(seed);
    wt(5);
    chk(mon, emon);
    mf <= 8'h00;
    wt(5);
    chk(ind.block_shown, 1'b1);
    chk(ge, 1'b0);
    run <= 1'b0;
    wt(5);
    run <= 1'b1;
    wt(5);
    chk(ind.block_shown, 1'b0);
    chk(ge, 1'b1);
    // timed deceleration, short enough for the test load
    bst <= 13'h2 + 13'($random(seed) & 1);
    restart;
    mf <= 8'h04;
    wt(5);
    chk(dr, 1'b1);
    chk(ge, 1'b1);
    wt(bst * TC + TC);
    chk(dr, 1'b0);
    chk(ge, 1'b0);
    results;
  end
  // watchdog sized well past the few hundred cycles the cases need
  initial
  begin
    #40000;
    errors++;
    results;
  end
endmodule : drive_protection_trip_logic_test
